// [bench/swr_host.sv]
// host model: issues single-byte register accesses toward the bank
`timescale 1ns/10ps
module swr_host (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output swr_pkg::swr_access_t acc
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus shows inverted address and data so a stale copy never looks valid
    initial acc = '0;

    // the host owns the checksum bit: whole byte must come out even
    function automatic logic [7:0] wd_sum(input logic [6:0] v);
        return {^v, v};
    endfunction

    // write: strobe and data held for exactly one sampling edge
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // read: data is registered at the edge that takes the strobe
    task automatic read(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~acc.wdata};
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~acc.wdata};
        #1 d = rdata;
    endtask
endmodule

// [bench/swr_regs_tb.sv]
// testbench: register bank driven by the host model, table rows then event cases
`timescale 1ns/10ps
module swr_regs_tb;
    ////////////////////////////////////////////////////////////////////////////////
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic [12:0] c;
    } swr_row_t;

    localparam int EV_SLEEP = 5;
    localparam int EV_STOP = 4;
    localparam int EV_FAIL = 3;
    localparam int EV_S2N = 2;
    localparam int EV_RESTART = 1;
    localparam int EV_SOFT = 0;

    logic mclk;
    logic resetn;
    swr_pkg::swr_access_t acc;
    swr_pkg::swr_event_t evt;
    logic system_error_flag;
    logic dev_mode;
    logic [1:0] restart_mode;
    logic hw_period_we;
    logic [2:0] hw_period;
    logic [7:0] rdata;
    swr_pkg::swr_ctrl_t ctrl;
    logic [12:0] cv;
    int num_errors;
    int n_compared;

    // rows run in order, so each expected control word is cumulative
    swr_row_t rows[12] = '{
        '{7'h03, 8'hE1, 8'hE1, 13'h18C1},
        '{7'h03, 8'h61, 8'h61, 13'h1881},
        '{7'h03, 8'h90, 8'h90, 13'h0441},
        '{7'h04, 8'hFF, 8'h07, 13'h0479},
        '{7'h04, 8'h06, 8'h06, 13'h0471},
        '{7'h06, 8'hFF, 8'h44, 13'h1475},
        '{7'h07, 8'hFF, 8'hA1, 13'h1476},
        '{7'h07, 8'h01, 8'h01, 13'h1475},
        '{7'h07, 8'h00, 8'h00, 13'h1474},
        '{7'h06, 8'h00, 8'h00, 13'h0470},
        '{7'h05, 8'hFF, 8'h00, 13'h0470},
        '{7'h2A, 8'hFF, 8'h00, 13'h0470}
    };

    assign cv = ctrl;

    swr_regs dut (
        .mclk(mclk),
        .resetn(resetn),
        .acc(acc),
        .evt(evt),
        .system_error_flag(system_error_flag),
        .dev_mode(dev_mode),
        .restart_mode(restart_mode),
        .hw_period_we(hw_period_we),
        .hw_period(hw_period),
        .rdata(rdata),
        .ctrl(ctrl)
    );

    swr_host host (
        .mclk(mclk),
        .rdata(rdata),
        .acc(acc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and a hard cap on run time
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #500000;
        $display("mismatch at %0t: run did not finish", $time);
        num_errors++;
        results();
    end

    // one-cycle device event pulse
    task automatic pulse(input int k);
        @(posedge mclk);
        evt <= swr_pkg::swr_event_t'(6'h01 << k);
        @(posedge mclk);
        evt <= '0;
    endtask

    task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read(a, d);
        `CHK(d, e)
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        resetn = 1'b0;
        evt = '0;
        system_error_flag = 1'b0;
        dev_mode = 1'b0;
        restart_mode = 2'h0;
        hw_period_we = 1'b0;
        hw_period = 3'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) begin
            host.write(rows[i].a, rows[i].d);
            chk_reg(rows[i].a, rows[i].r);
            `CHK(cv, rows[i].c)
        end
        // host-computed checksum, then a hardware update of the period
        host.write(7'h03, host.wd_sum(7'h25));
        #1;
        `CHK(ctrl.wd_parity_ok, 1'b1)
        @(posedge mclk);
        hw_period <= 3'h2;
        hw_period_we <= 1'b1;
        @(posedge mclk);
        hw_period_we <= 1'b0;
        chk_reg(7'h03, 8'hA2);
        // sleep: normal and receive-only fall to wake capable, top bit untouched
        for (int m = 0; m < 8; m++) begin
            host.write(7'h04, 8'(m));
            system_error_flag <= (m[1:0] != 2'h3) && m[2];
            pulse(EV_SLEEP);
            chk_reg(7'h04, {5'h00, m[2], (m[1] ? 2'h1 : m[1:0])});
        end
        system_error_flag <= 1'b0;
        // stop leaves receive-only, wake capable and off alone
        for (int m = 0; m < 8; m++) begin
            if (m[1:0] != 2'h3) begin
                host.write(7'h04, 8'(m));
                pulse(EV_STOP);
                chk_reg(7'h04, 8'(m));
            end
        end
        for (int m = 0; m < 8; m++) begin
            host.write(7'h04, 8'(m));
            pulse(EV_FAIL);
            chk_reg(7'h04, {5'h00, m[2], 2'h1});
        end
        // leaving stop clears only the second watchdog-off bit
        host.write(7'h06, 8'h44);
        #1;
        `CHK(ctrl.stop_wd_off, 1'b1)
        pulse(EV_S2N);
        chk_reg(7'h06, 8'h40);
        `CHK(ctrl.stop_wd_off, 1'b0)
        // restart with preloaded registers
        host.write(7'h03, 8'hE1);
        host.write(7'h04, 8'h07);
        host.write(7'h06, 8'h44);
        host.write(7'h07, 8'hA1);
        restart_mode <= 2'h2;
        pulse(EV_RESTART);
        chk_reg(7'h03, 8'hA4);
        chk_reg(7'h04, 8'h02);
        chk_reg(7'h06, 8'h40);
        chk_reg(7'h07, 8'hA1);
        // soft reset with the development strap, then without
        dev_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        pulse(EV_SOFT);
        chk_reg(7'h04, 8'h03);
        chk_reg(7'h03, 8'h14);
        dev_mode <= 1'b0;
        repeat (3) @(posedge mclk);
        pulse(EV_SOFT);
        chk_reg(7'h04, 8'h00);
        // second hard reset in mid-run, strap set so power-on loads normal mode
        dev_mode <= 1'b1;
        host.write(7'h06, 8'h44);
        resetn <= 1'b0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK(cv, 13'h0641)
        chk_reg(7'h03, 8'h14);
        chk_reg(7'h04, 8'h03);
        chk_reg(7'h06, 8'h00);
        chk_reg(7'h07, 8'h01);
        results();
    end
endmodule

// [verilog/swr_can_mode.sv]
// module: next-value logic of the transceiver mode field on low-power and fail-safe entry
`timescale 1ns/10ps
module swr_can_mode (
    input wire logic [2:0] cur_mode,
    input wire logic system_error_flag,
    input wire swr_pkg::swr_event_t evt,
    input wire logic [1:0] restart_mode,
    output logic [2:0] auto_mode,
    output logic auto_change
);

    // sleep and fail-safe touch only the lower two bits and pass the selective bit through; restart clears it
    always_comb begin
        auto_mode = cur_mode;
        auto_change = 1'b0;
        if (evt.restart) begin
            auto_mode = {1'b0, restart_mode};
            auto_change = 1'b1;
        end else if (evt.enter_fail_safe) begin
            auto_mode = {cur_mode[2], swr_pkg::CAN_WAKE_CAPABLE};
            auto_change = 1'b1;
        end else if (evt.enter_sleep) begin
            if ((cur_mode[1:0] == swr_pkg::CAN_NORMAL) && !system_error_flag) begin
                auto_mode = {cur_mode[2], swr_pkg::CAN_WAKE_CAPABLE};
                auto_change = 1'b1;
            end else if (cur_mode[1:0] == swr_pkg::CAN_RECEIVE_ONLY) begin
                auto_mode = {cur_mode[2], swr_pkg::CAN_WAKE_CAPABLE};
                auto_change = 1'b1;
            end
            // off and wake capable stay as they are
        end
        // Stop entry leaves receive-only untouched, the host chose it beforehand
    end

endmodule

// [verilog/swr_parity.sv]
// module: even-parity check of the watchdog control byte
`timescale 1ns/10ps
module swr_parity (
    input wire logic [7:0] data,
    output logic even_ok
);

    // whole byte including the checksum bit must sum even
    assign even_ok = ~(^data);

endmodule

// [verilog/swr_pkg.sv]
// package: register map, field positions, reset values and carrier types of the wake/watchdog bank
package swr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses (7-bit serial address space)
    localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;
    localparam logic [6:0] ADDR_TRANSCEIVER_MODE = 7'h04;
    localparam logic [6:0] ADDR_INTERNAL_WAKE = 7'h06;
    localparam logic [6:0] ADDR_EXTERNAL_WAKE = 7'h07;

    ////////////////////////////////////////////////////////////////////////////////
    // power-on / soft-reset values
    localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h14;
    localparam logic [7:0] RST_TRANSCEIVER_MODE = 8'h00;
    localparam logic [7:0] RST_INTERNAL_WAKE = 8'h00;
    localparam logic [7:0] RST_EXTERNAL_WAKE = 8'h01;
    localparam logic [2:0] DEV_MODE_RESET_CAN = 3'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h2; // cycles after release until the strap is valid

    // writable masks; zero positions are reserved and read zero
    localparam logic [7:0] MASK_WATCHDOG_CONTROL = 8'hF7;
    localparam logic [7:0] MASK_TRANSCEIVER_MODE = 8'h07;
    localparam logic [7:0] MASK_INTERNAL_WAKE = 8'h44;
    localparam logic [7:0] MASK_EXTERNAL_WAKE = 8'hA1;

    // restart keeps these bits, zeroes the rest, then forces ones
    localparam logic [7:0] RESTART_KEEP_WATCHDOG = 8'hB0;
    localparam logic [7:0] RESTART_SET_WATCHDOG = 8'h04;
    localparam logic [7:0] RESTART_KEEP_INTERNAL = 8'h40;
    localparam logic [7:0] RESTART_KEEP_EXTERNAL = 8'hA1;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int POS_CHECKSUM = 7;
    localparam int POS_STOP_WD_OFF_A = 6;
    localparam int POS_WINDOW_TYPE = 5;
    localparam int POS_WD_ON_BUS_WAKE = 4;
    localparam int POS_SELECTIVE_WAKE = 2;
    localparam int POS_TIMER_WAKE = 6;
    localparam int POS_STOP_WD_OFF_B = 2;
    localparam int POS_INT_GLOBAL = 7;
    localparam int POS_VOLTAGE_SENSE = 5;
    localparam int POS_HV_WAKE = 0;

    // transceiver lower mode codes
    localparam logic [1:0] CAN_OFF = 2'h0;
    localparam logic [1:0] CAN_WAKE_CAPABLE = 2'h1;
    localparam logic [1:0] CAN_RECEIVE_ONLY = 2'h2;
    localparam logic [1:0] CAN_NORMAL = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // host access carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } swr_access_t;

    // decoded controls toward the device functions
    typedef struct packed {
        logic stop_wd_off;
        logic window_type_select;
        logic watchdog_on_bus_wake;
        logic [2:0] watchdog_period_field;
        logic wd_parity_ok;
        logic selective_wake;
        logic [1:0] can_mode;
        logic timer_wake_enable;
        logic int_global;
        logic hv_wake_active;
    } swr_ctrl_t;

    // device events from the mode state machine
    typedef struct packed {
        logic enter_sleep;
        logic enter_stop;
        logic enter_fail_safe;
        logic stop_to_normal;
        logic restart;
        logic soft_reset;
    } swr_event_t;

endpackage

// [verilog/swr_regs.sv]
// module: watchdog, transceiver mode and wake control register bank
`timescale 1ns/10ps
module swr_regs (
    input wire logic mclk,
    input wire logic resetn,
    input wire swr_pkg::swr_access_t acc,
    input wire swr_pkg::swr_event_t evt,
    input wire logic system_error_flag,
    input wire logic dev_mode,
    input wire logic [1:0] restart_mode,
    input wire logic hw_period_we,
    input wire logic [2:0] hw_period,
    output logic [7:0] rdata,
    output swr_pkg::swr_ctrl_t ctrl
);

    logic [7:0] watchdog_control;
    logic [7:0] transceiver_mode_control;
    logic [7:0] internal_wake_control;
    logic [7:0] external_wake_control;
    logic [7:0] next_watchdog_control;
    logic [7:0] next_transceiver_mode_control;
    logic [7:0] next_internal_wake_control;
    logic [7:0] next_external_wake_control;
    logic [7:0] next_rdata;
    swr_pkg::swr_ctrl_t next_ctrl;
    logic [2:0] auto_mode;
    logic auto_change;
    logic parity_ok;
    logic dev_mode_s1;
    logic dev_mode_s2;
    logic wr_wd;
    logic wr_can;
    logic wr_iw;
    logic wr_ew;
    logic [1:0] strap_wait;
    logic [1:0] next_strap_wait;
    logic [7:0] rd_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // strap synchroniser; development pin comes from outside the clock domain
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dev_mode_s1 <= 1'b0;
            dev_mode_s2 <= 1'b0;
        end else begin
            dev_mode_s1 <= dev_mode;
            dev_mode_s2 <= dev_mode_s1;
        end
    end

    swr_can_mode u_can_mode (
        .cur_mode(transceiver_mode_control[2:0]),
        .system_error_flag(system_error_flag),
        .evt(evt),
        .restart_mode(restart_mode),
        .auto_mode(auto_mode),
        .auto_change(auto_change)
    );

    swr_parity u_parity (
        .data(next_watchdog_control),
        .even_ok(parity_ok)
    );

    // write strobes by address
    assign wr_wd = acc.wr && (acc.addr == swr_pkg::ADDR_WATCHDOG_CONTROL);
    assign wr_can = acc.wr && (acc.addr == swr_pkg::ADDR_TRANSCEIVER_MODE);
    assign wr_iw = acc.wr && (acc.addr == swr_pkg::ADDR_INTERNAL_WAKE);
    assign wr_ew = acc.wr && (acc.addr == swr_pkg::ADDR_EXTERNAL_WAKE);

    // implemented positions of the addressed register; everything else must read zero
    always_comb begin
        case (acc.addr)
            swr_pkg::ADDR_WATCHDOG_CONTROL: rd_mask = swr_pkg::MASK_WATCHDOG_CONTROL;
            swr_pkg::ADDR_TRANSCEIVER_MODE: rd_mask = swr_pkg::MASK_TRANSCEIVER_MODE;
            swr_pkg::ADDR_INTERNAL_WAKE: rd_mask = swr_pkg::MASK_INTERNAL_WAKE;
            swr_pkg::ADDR_EXTERNAL_WAKE: rd_mask = swr_pkg::MASK_EXTERNAL_WAKE;
            default: rd_mask = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next register values; soft reset beats restart beats hardware beats host write
    always_comb begin
        next_watchdog_control = watchdog_control;
        next_transceiver_mode_control = transceiver_mode_control;
        next_internal_wake_control = internal_wake_control;
        next_external_wake_control = external_wake_control;
        // settle counter stops at its top so the power-on strap load happens once
        next_strap_wait = strap_wait;
        if (strap_wait != 2'h3) begin
            next_strap_wait = 2'(strap_wait + 2'h1);
        end
        if (evt.soft_reset) begin
            next_watchdog_control = swr_pkg::RST_WATCHDOG_CONTROL;
            next_transceiver_mode_control = swr_pkg::RST_TRANSCEIVER_MODE;
            if (dev_mode_s2) begin
                next_transceiver_mode_control[2:0] = swr_pkg::DEV_MODE_RESET_CAN;
            end
            next_internal_wake_control = swr_pkg::RST_INTERNAL_WAKE;
            next_external_wake_control = swr_pkg::RST_EXTERNAL_WAKE;
        end else if (evt.restart) begin
            next_watchdog_control = (watchdog_control & swr_pkg::RESTART_KEEP_WATCHDOG)
                | swr_pkg::RESTART_SET_WATCHDOG;
            next_transceiver_mode_control = {5'h00, auto_mode};
            next_internal_wake_control = internal_wake_control & swr_pkg::RESTART_KEEP_INTERNAL;
            next_external_wake_control = external_wake_control & swr_pkg::RESTART_KEEP_EXTERNAL;
        end else begin
            // power-on strap load waits for the synchroniser; a host write still wins
            if ((strap_wait == swr_pkg::STRAP_SETTLE) && dev_mode_s2) begin
                next_transceiver_mode_control[1:0] = swr_pkg::DEV_MODE_RESET_CAN[1:0];
            end
            // host writes; reserved positions masked so they read zero
            if (wr_wd) begin
                next_watchdog_control = acc.wdata & swr_pkg::MASK_WATCHDOG_CONTROL;
            end
            if (wr_can) begin
                next_transceiver_mode_control = acc.wdata & swr_pkg::MASK_TRANSCEIVER_MODE;
            end
            if (wr_iw) begin
                next_internal_wake_control = acc.wdata & swr_pkg::MASK_INTERNAL_WAKE;
            end
            if (wr_ew) begin
                next_external_wake_control = acc.wdata & swr_pkg::MASK_EXTERNAL_WAKE;
            end
            // hardware updates win over a simultaneous host write of the same bits
            if (hw_period_we) begin
                next_watchdog_control[2:0] = hw_period;
            end
            if (auto_change) begin
                next_transceiver_mode_control[1:0] = auto_mode[1:0];
                if (evt.enter_fail_safe) begin
                    next_transceiver_mode_control[7:3] = 5'h00;
                end
            end
            if (evt.stop_to_normal) begin
                next_internal_wake_control[swr_pkg::POS_STOP_WD_OFF_B] = 1'b0;
            end
        end
    end

    // read mux and decoded controls
    always_comb begin
        next_rdata = rdata;
        if (acc.rd) begin
            case (acc.addr)
                swr_pkg::ADDR_WATCHDOG_CONTROL: next_rdata = watchdog_control;
                swr_pkg::ADDR_TRANSCEIVER_MODE: next_rdata = transceiver_mode_control;
                swr_pkg::ADDR_INTERNAL_WAKE: next_rdata = internal_wake_control;
                swr_pkg::ADDR_EXTERNAL_WAKE: next_rdata = external_wake_control;
                default: next_rdata = 8'h00;
            endcase
        end
        // either stop-off bit deactivates the watchdog in Stop
        next_ctrl.stop_wd_off = next_watchdog_control[swr_pkg::POS_STOP_WD_OFF_A]
            | next_internal_wake_control[swr_pkg::POS_STOP_WD_OFF_B];
        next_ctrl.window_type_select = next_watchdog_control[swr_pkg::POS_WINDOW_TYPE];
        next_ctrl.watchdog_on_bus_wake = next_watchdog_control[swr_pkg::POS_WD_ON_BUS_WAKE];
        next_ctrl.watchdog_period_field = next_watchdog_control[2:0];
        next_ctrl.wd_parity_ok = parity_ok;
        next_ctrl.selective_wake = next_transceiver_mode_control[2]
            && (next_transceiver_mode_control[1:0] != swr_pkg::CAN_OFF);
        next_ctrl.can_mode = next_transceiver_mode_control[1:0];
        next_ctrl.timer_wake_enable = next_internal_wake_control[swr_pkg::POS_TIMER_WAKE];
        next_ctrl.int_global = next_external_wake_control[swr_pkg::POS_INT_GLOBAL];
        // voltage sensing takes the pin away from wake duty
        next_ctrl.hv_wake_active = next_external_wake_control[swr_pkg::POS_HV_WAKE]
            && !next_external_wake_control[swr_pkg::POS_VOLTAGE_SENSE];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; async reset loads constants only, the strap lands once synchronised
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            watchdog_control <= swr_pkg::RST_WATCHDOG_CONTROL;
            transceiver_mode_control <= swr_pkg::RST_TRANSCEIVER_MODE;
            internal_wake_control <= swr_pkg::RST_INTERNAL_WAKE;
            external_wake_control <= swr_pkg::RST_EXTERNAL_WAKE;
            rdata <= 8'h00;
            ctrl <= '0;
            strap_wait <= 2'h0;
        end else begin
            watchdog_control <= next_watchdog_control;
            transceiver_mode_control <= next_transceiver_mode_control;
            internal_wake_control <= next_internal_wake_control;
            external_wake_control <= next_external_wake_control;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            strap_wait <= next_strap_wait;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_sel_bit_kept: assert property (@(posedge mclk) disable iff (!resetn)
        !wr_can && !evt.soft_reset && !evt.restart
        |=> transceiver_mode_control[2] == $past(transceiver_mode_control[2]))
        else $error("selective wake bit changed without host write");
    a_sleep_normal: assert property (@(posedge mclk) disable iff (!resetn)
        evt.enter_sleep && !evt.soft_reset && !evt.restart && !evt.enter_fail_safe
        && !system_error_flag && transceiver_mode_control[1:0] == 2'h3
        |=> transceiver_mode_control[1:0] == 2'h1)
        else $error("normal mode not turned wake capable on sleep");
    a_stop_rx_kept: assert property (@(posedge mclk) disable iff (!resetn)
        evt.enter_stop && !evt.enter_sleep && !evt.enter_fail_safe && !evt.restart
        && !evt.soft_reset && !wr_can && transceiver_mode_control[1:0] == 2'h2
        |=> transceiver_mode_control[1:0] == 2'h2)
        else $error("receive only lost on stop entry");
    a_lowpwr_keep: assert property (@(posedge mclk) disable iff (!resetn)
        (evt.enter_sleep || evt.enter_stop) && !evt.enter_fail_safe && !evt.restart
        && !evt.soft_reset && !wr_can && !transceiver_mode_control[1]
        |=> transceiver_mode_control == $past(transceiver_mode_control))
        else $error("off or wake capable changed on low power entry");
    a_failsafe_val: assert property (@(posedge mclk) disable iff (!resetn)
        evt.enter_fail_safe && !evt.restart && !evt.soft_reset
        |=> transceiver_mode_control[7:3] == 5'h00 && transceiver_mode_control[1:0] == 2'h1)
        else $error("fail-safe did not force wake capable");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
        acc.rd |=> (rdata & ~$past(rd_mask)) == 8'h00)
        else $error("reserved bit read nonzero");
    a_stop_normal: assert property (@(posedge mclk) disable iff (!resetn)
        evt.stop_to_normal && !evt.soft_reset && !evt.restart
        |=> !internal_wake_control[swr_pkg::POS_STOP_WD_OFF_B]
        && (ctrl.stop_wd_off == watchdog_control[swr_pkg::POS_STOP_WD_OFF_A]))
        else $error("second stop off bit not cleared");
    a_dev_reset: assert property (@(posedge mclk) disable iff (!resetn)
        evt.soft_reset && dev_mode_s2 |=> transceiver_mode_control == 8'h03)
        else $error("development reset mode not normal");
    a_sense_nowake: assert property (@(posedge mclk) disable iff (!resetn)
        external_wake_control[5] |-> !ctrl.hv_wake_active)
        else $error("wake active while sensing voltage");

endmodule
